// ### logic/dch_status_params.svh
`ifndef DCH_STATUS_PARAMS_SVH
`define DCH_STATUS_PARAMS_SVH
// register byte addresses on the local port (16-bit address space)
`define ADDR_W 16
`define OFF_DCH_STATUS 16'hffe4
`define OFF_INT_SOURCE0 16'hffe8
`define OFF_INT_MASK0 16'hffe9
`define OFF_DEVICE_MODE 16'hffea
`define OFF_TX_CONTROL 16'hffeb
`define OFF_TX_BYTE0 16'hfff0
`define OFF_RX_BYTE0 16'hfff8
`define BUF_BYTES 6
`define RX_LAST_INDEX 3'h5
// field positions
`define MODE_DOUBLE_BIT 6
`define TXCTL_EMPTY_DEF_BIT 1
`define ST_RX_FULL_S 0
`define ST_RX_ERR 1
`define ST_TX_EMPTY 2
`define ST_RX_HALF_D 0
`define ST_RX_FULL_D 3
`define ST_TX_HALF_D 4
`define ST_TX_UF_D 5
`define ST_RX_OVF_D 6
// reset values
`define STATUS_RESET 8'h04
`define SRC_MASK_RESET 3'h0
`endif

// ### logic/dch_status_pkg.sv
package dch_status_pkg;
    typedef logic [15:0] addr_type;
    typedef logic [7:0] byte_type;
    typedef enum logic {
        SINGLE_BUF,
        DOUBLE_BUF
    } buf_mode_type;
endpackage : dch_status_pkg

// ### logic/word_counter.sv
`timescale 1ns/100ps
// counts code words held in a two-deep buffer; saturates at both ends
module word_counter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic inc,
    input wire logic dec,
    output logic [1:0] count_q
);
    logic [1:0] count_d;

    always_comb begin
        count_d = count_q;
        if (inc && !dec && count_q != 2'h2) begin
            count_d = count_q + 2'h1;
        end else if (dec && !inc && count_q != 2'h0) begin
            count_d = count_q - 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_q <= 2'h0;
        end else begin
            count_q <= count_d;
        end
    end
endmodule : word_counter

// ### logic/d_channel_buffer_status.sv
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
`include "dch_status_params.svh"
// What this block does
// - low three status bits feed source register bits, gated by mask bits.
// - mode bit clear: tx empty bit 2, rx error bit 1, rx full bit 0.
// - single mode tx empty set from reset, cleared by any tx byte write.
// - tx control bit 1 selects what counts as tx empty in single mode.
// - single mode rx error set on crc/parity/overflow, cleared by status read.
// - single mode rx full set at six bytes, cleared by last byte read.
// - mode bit set: double buffer layout of seven flags.
// - double mode top bit always reads zero.
// - double mode overflow flag set on rx overflow, zero after reset.
// - double mode underflow set on tx underflow, cleared by status read.
// - tx half empty high with one word or less, set after reset.
// - double mode rx full high with two words, low after reset.
// - double mode tx empty high with no words, active from reset.
// - rx error shows visible word's error; reading a half switches halves.
// - rx half full high with at least one complete word.
module d_channel_buffer_status
    import dch_status_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire dch_status_pkg::addr_type addr,
    input wire dch_status_pkg::byte_type wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output dch_status_pkg::byte_type rdata,
    input wire logic rx_crc_err,
    input wire logic rx_parity_err,
    input wire logic rx_overflow,
    input wire logic rx_byte_done,
    input wire logic rx_word_done,
    input wire logic tx_word_sent,
    input wire logic tx_underflow,
    input wire logic tx_frame_idle,
    output logic irq
);
    import dch_status_pkg::*;

    byte_type rdata_q, rdata_d;
    logic irq_q, irq_d;
    logic [2:0] src_q, src_d;
    logic [2:0] mask_q, mask_d;
    byte_type mode_q, mode_d;
    byte_type txctl_q, txctl_d;
    logic tx_empty_q, tx_empty_d;
    logic rx_err_q, rx_err_d;
    logic rx_full_q, rx_full_d;
    logic [2:0] rx_bytes_q, rx_bytes_d;
    logic uf_q, uf_d;
    logic ovf_q, ovf_d;
    logic [1:0] err_half_q, err_half_d;
    logic vis_q, vis_d;
    logic stat_rd_q, stat_rd_d;
    logic [1:0] tx_words, rx_words;
    byte_type status;
    buf_mode_type mode;

    function automatic logic in_window(input addr_type a, input addr_type base);
        in_window = a >= base && a < base + addr_type'(`BUF_BYTES);
    endfunction : in_window

    wire tx_wr = wr_en && in_window(addr, `OFF_TX_BYTE0);
    wire rx_rd = rd_en && in_window(addr, `OFF_RX_BYTE0);
    wire rx_last_rd = rd_en && addr == `OFF_RX_BYTE0 + 16'(`RX_LAST_INDEX);
    wire stat_rd = rd_en && addr == `OFF_DCH_STATUS;
    wire rx_err_ev = rx_crc_err || rx_parity_err;

    assign mode = mode_q[`MODE_DOUBLE_BIT] ? DOUBLE_BUF : SINGLE_BUF;

    // a word is loaded on its last byte write; a word is taken on last read
    word_counter u_tx_words (
        .clk(clk),
        .rst_n(rst_n),
        .inc(tx_wr && addr == `OFF_TX_BYTE0 + 16'(`RX_LAST_INDEX)),
        .dec(tx_word_sent),
        .count_q(tx_words)
    );

    word_counter u_rx_words (
        .clk(clk),
        .rst_n(rst_n),
        .inc(rx_word_done),
        .dec(rx_last_rd),
        .count_q(rx_words)
    );

    // status as software sees it in the current mode
    always_comb begin
        status = 8'h00;
        if (mode == SINGLE_BUF) begin
            status[`ST_TX_EMPTY] = tx_empty_q;
            status[`ST_RX_ERR] = rx_err_q;
            status[`ST_RX_FULL_S] = rx_full_q;
        end else begin
            status[`ST_RX_OVF_D] = ovf_q;
            status[`ST_TX_UF_D] = uf_q;
            status[`ST_TX_HALF_D] = tx_words != 2'h2;
            status[`ST_RX_FULL_D] = rx_words == 2'h2;
            status[`ST_TX_EMPTY] = tx_words == 2'h0;
            status[`ST_RX_ERR] = err_half_q[vis_q];
            status[`ST_RX_HALF_D] = rx_words != 2'h0;
            status[7] = 1'b0;
        end
    end

    // flags: set beats a coincident clear everywhere
    always_comb begin
        tx_empty_d = tx_empty_q;
        rx_err_d = rx_err_q;
        rx_full_d = rx_full_q;
        rx_bytes_d = rx_bytes_q;
        uf_d = uf_q;
        ovf_d = ovf_q;
        err_half_d = err_half_q;
        vis_d = vis_q;
        stat_rd_d = stat_rd;
        // single mode tx empty: bit 1 of tx control picks frame-idle as empty
        if (tx_wr) begin
            tx_empty_d = 1'b0;
        end
        if (txctl_q[`TXCTL_EMPTY_DEF_BIT] ? tx_frame_idle : tx_word_sent) begin
            tx_empty_d = 1'b1;
        end
        // status read clears take effect one cycle after the read
        if (stat_rd_q) begin
            rx_err_d = 1'b0;
            uf_d = 1'b0;
        end
        if (rx_err_ev || rx_overflow) begin
            rx_err_d = 1'b1;
        end
        if (tx_underflow) begin
            uf_d = 1'b1;
        end
        if (rx_overflow) begin
            ovf_d = 1'b1;
        end else if (rx_rd) begin
            ovf_d = 1'b0;
        end
        if (rx_last_rd) begin
            rx_full_d = 1'b0;
            rx_bytes_d = 3'h0;
            err_half_d[vis_q] = 1'b0;
            vis_d = ~vis_q;
        end
        if (rx_byte_done) begin
            if (rx_bytes_q == 3'(`BUF_BYTES - 1)) begin
                rx_full_d = 1'b1;
                rx_bytes_d = 3'h0;
            end else begin
                rx_bytes_d = rx_bytes_q + 3'h1;
            end
        end
        // error belongs to the half being filled: the visible one when no word is held, else the other
        if (rx_err_ev) begin
            err_half_d[rx_words == 2'h0 ? vis_q : ~vis_q] = 1'b1;
        end
    end

    // registers, interrupt and read port
    always_comb begin
        mask_d = mask_q;
        mode_d = mode_q;
        txctl_d = txctl_q;
        if (wr_en && addr == `OFF_INT_MASK0) begin
            mask_d = wdata[2:0];
        end
        if (wr_en && addr == `OFF_DEVICE_MODE) begin
            mode_d = wdata;
        end
        if (wr_en && addr == `OFF_TX_CONTROL) begin
            txctl_d = wdata;
        end
        src_d = status[2:0] & mask_q;
        irq_d = |src_d;
        rdata_d = 8'h00;
        if (rd_en) begin
            case (addr)
                `OFF_DCH_STATUS: rdata_d = status;
                `OFF_INT_SOURCE0: rdata_d = {5'h00, src_q};
                `OFF_INT_MASK0: rdata_d = {5'h00, mask_q};
                `OFF_DEVICE_MODE: rdata_d = mode_q;
                `OFF_TX_CONTROL: rdata_d = txctl_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_empty_q <= 1'b1;
            rx_err_q <= 1'b0;
            rx_full_q <= 1'b0;
            rx_bytes_q <= 3'h0;
            uf_q <= 1'b0;
            ovf_q <= 1'b0;
            err_half_q <= 2'h0;
            vis_q <= 1'b0;
            stat_rd_q <= 1'b0;
            mask_q <= `SRC_MASK_RESET;
            mode_q <= 8'h00;
            txctl_q <= 8'h00;
            src_q <= 3'h0;
            irq_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            tx_empty_q <= tx_empty_d;
            rx_err_q <= rx_err_d;
            rx_full_q <= rx_full_d;
            rx_bytes_q <= rx_bytes_d;
            uf_q <= uf_d;
            ovf_q <= ovf_d;
            err_half_q <= err_half_d;
            vis_q <= vis_d;
            stat_rd_q <= stat_rd_d;
            mask_q <= mask_d;
            mode_q <= mode_d;
            txctl_q <= txctl_d;
            src_q <= src_d;
            irq_q <= irq_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;
    assign irq = irq_q;

    // checks on the flags and on what software reads back
    AST_SRC_GATED: assert property (
        @(posedge clk) disable iff (!rst_n)
        src_q == ($past(status[2:0]) & $past(mask_q)))
        else $error("source bits not status gated by mask");
    AST_TOP_ZERO: assert property (
        @(posedge clk) disable iff (!rst_n)
        stat_rd && mode == DOUBLE_BUF |=> !rdata_q[7])
        else $error("reserved status bit read as one");
    AST_TXE_CLR: assert property (
        @(posedge clk) disable iff (!rst_n)
        tx_wr && !tx_frame_idle && !tx_word_sent |=> !tx_empty_q)
        else $error("tx empty not cleared by write");
    AST_ERR_SET: assert property (
        @(posedge clk) disable iff (!rst_n)
        rx_overflow |=> rx_err_q)
        else $error("rx error not set");
    AST_RD_CLR: assert property (
        @(posedge clk) disable iff (!rst_n)
        stat_rd ##1 !(rx_err_ev || rx_overflow) |=> !rx_err_q)
        else $error("status read did not clear error");
    AST_FULL_CLR: assert property (
        @(posedge clk) disable iff (!rst_n)
        rx_last_rd && !rx_byte_done |=> !rx_full_q)
        else $error("rx full not cleared");
    AST_UF_SET: assert property (
        @(posedge clk) disable iff (!rst_n)
        tx_underflow |=> uf_q)
        else $error("underflow not set");
    AST_OVF_SET: assert property (
        @(posedge clk) disable iff (!rst_n)
        rx_overflow |=> ovf_q)
        else $error("overflow not set");
    AST_IRQ: assert property (
        @(posedge clk) disable iff (!rst_n)
        irq == |($past(status[2:0]) & $past(mask_q)))
        else $error("irq not tied to unmasked status");
    AST_TXE_SET: assert property (
        @(posedge clk) disable iff (!rst_n)
        (txctl_q[`TXCTL_EMPTY_DEF_BIT] ? tx_frame_idle : tx_word_sent)
        |=> tx_empty_q)
        else $error("tx empty not set by chosen condition");
    AST_FULL_SET: assert property (
        @(posedge clk) disable iff (!rst_n)
        rx_byte_done && rx_bytes_q == 3'(`BUF_BYTES - 1) |=> rx_full_q)
        else $error("rx full not set at last byte");
    AST_UF_CLR: assert property (
        @(posedge clk) disable iff (!rst_n)
        stat_rd ##1 !tx_underflow |=> !uf_q)
        else $error("status read did not clear underflow");
    AST_CLR_LATE: assert property (
        @(posedge clk) disable iff (!rst_n)
        stat_rd && !stat_rd_q && rx_err_q |=> rx_err_q)
        else $error("rx error cleared in the read cycle");
    AST_SGL_RSVD: assert property (
        @(posedge clk) disable iff (!rst_n)
        stat_rd && mode == SINGLE_BUF |=> rdata_q[7:3] == 5'h00)
        else $error("reserved single mode bits read as one");
    AST_RST_VALS: assert property (
        @(posedge clk)
        !rst_n |=> tx_empty_q && !ovf_q && !uf_q && tx_words == 2'h0
            && rx_words == 2'h0 && mode_q == 8'h00)
        else $error("flags not at reset values");
    AST_VIS_SWAP: assert property (
        @(posedge clk) disable iff (!rst_n)
        rx_last_rd |=> vis_q != $past(vis_q))
        else $error("last byte read did not switch halves");
    AST_ERR_HALF: assert property (
        @(posedge clk) disable iff (!rst_n)
        rx_err_ev && rx_words == 2'h0 && !rx_last_rd |=> err_half_q[vis_q])
        else $error("error not marked on the visible word");
    AST_OVF_CLR: assert property (
        @(posedge clk) disable iff (!rst_n)
        rx_rd && !rx_overflow |=> !ovf_q)
        else $error("overflow not cleared by buffer read");
    AST_RX_FULL_D: assert property (
        @(posedge clk) disable iff (!rst_n)
        rx_word_done && !rx_last_rd && rx_words == 2'h1 |=> rx_words == 2'h2)
        else $error("second word did not fill rx buffer");
    AST_TX_EMPTY_D: assert property (
        @(posedge clk) disable iff (!rst_n)
        tx_word_sent && !tx_wr && tx_words != 2'h0
        |=> tx_words == $past(tx_words) - 2'h1)
        else $error("sent word not taken from tx count");
    AST_HALF_D: assert property (
        @(posedge clk) disable iff (!rst_n)
        rx_word_done && !rx_last_rd |=> rx_words != 2'h0)
        else $error("complete word not counted");
    AST_TX_HALF: assert property (
        @(posedge clk) disable iff (!rst_n)
        stat_rd && mode == DOUBLE_BUF && tx_words == 2'h2
        |=> !rdata_q[`ST_TX_HALF_D])
        else $error("half empty shown with two words");
endmodule : d_channel_buffer_status

// ### tb/testbench.sv
`timescale 1ns/100ps
`include "dch_status_params.svh"
module testbench;
    import dch_status_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    addr_type addr = 16'h0000;
    byte_type wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    byte_type rdata;
    // event pulses: crc, parity, ovf, byte, word, sent, underflow, idle
    logic [7:0] ev_q = 8'h00;
    logic irq;
    int fails = 0;
    int cmp_count = 0;
    int n;
    byte_type got;

    d_channel_buffer_status uut (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .rx_crc_err(ev_q[0]), .rx_parity_err(ev_q[1]),
        .rx_overflow(ev_q[2]), .rx_byte_done(ev_q[3]),
        .rx_word_done(ev_q[4]), .tx_word_sent(ev_q[5]),
        .tx_underflow(ev_q[6]), .tx_frame_idle(ev_q[7]), .irq(irq)
    );

    initial begin
        forever #20 clk = ~clk;
    end

    function automatic byte_type sgl(int txe, int err, int full);
        return {5'h00, txe[0], err[0], full[0]};
    endfunction : sgl

    function automatic byte_type dbl(int rxw, int txw, int uf, int ovf);
        return {1'b0, ovf[0], uf[0], txw <= 1, rxw == 2, txw == 0, 1'b0,
            rxw >= 1};
    endfunction : dbl

    task give_verdict;
        if (fails == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    task chk(input string name, input byte_type exp, input byte_type seen);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task wr(input addr_type a, input byte_type d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    // read data only stand in the cycle after the strobe
    task rd(input addr_type a, output byte_type d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd

    task rdc(input string name, input addr_type a, input byte_type exp);
        rd(a, got);
        chk(name, exp, got);
    endtask : rdc

    task ev(input logic [7:0] v);
        @(posedge clk);
        ev_q <= v;
        @(posedge clk);
        ev_q <= 8'h00;
    endtask : ev

    // irq is registered behind the flags, so allow three cycles
    task irqc(input logic exp);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("irq", {7'h00, exp}, {7'h00, irq});
    endtask : irqc

    initial begin
        n = $urandom(11588);
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rdc("status", `OFF_DCH_STATUS, sgl(1, 0, 0));
        rdc("mask", `OFF_INT_MASK0, 8'h00);
        irqc(1'b0);
        wr(`OFF_INT_MASK0, 8'h04);
        irqc(1'b1);
        rdc("source", `OFF_INT_SOURCE0, 8'h04);
        wr(`OFF_INT_MASK0, 8'h03);
        irqc(1'b0);
        wr(`OFF_TX_BYTE0, byte_type'($urandom));
        rdc("status", `OFF_DCH_STATUS, sgl(0, 0, 0));
        ev(8'h20);
        rdc("status", `OFF_DCH_STATUS, sgl(1, 0, 0));
        wr(`OFF_TX_BYTE0 + 16'h0001, byte_type'($urandom));
        wr(`OFF_TX_CONTROL, 8'h02);
        ev(8'h20);
        rdc("status", `OFF_DCH_STATUS, sgl(0, 0, 0));
        ev(8'h80);
        rdc("status", `OFF_DCH_STATUS, sgl(1, 0, 0));
        wr(`OFF_TX_BYTE0 + 16'h0002, byte_type'($urandom));
        for (int i = 0; i < 3; i++) begin
            ev(8'h01 << i);
            irqc(1'b1);
            rdc("status", `OFF_DCH_STATUS, sgl(0, 1, 0));
            rdc("status", `OFF_DCH_STATUS, sgl(0, 0, 0));
            irqc(1'b0);
        end
        wr(`OFF_DCH_STATUS, 8'hff);
        rdc("status", `OFF_DCH_STATUS, sgl(0, 0, 0));
        n = $urandom % 6;
        repeat (n) ev(8'h08);
        rdc("status", `OFF_DCH_STATUS, sgl(0, 0, 0));
        repeat (6 - n) ev(8'h08);
        rdc("status", `OFF_DCH_STATUS, sgl(0, 0, 1));
        irqc(1'b1);
        rd(`OFF_RX_BYTE0 + 16'h0005, got);
        rdc("status", `OFF_DCH_STATUS, sgl(0, 0, 0));
        repeat (4) rdc("unmapped", addr_type'($urandom) & 16'h7fff, 8'h00);
        wr(`OFF_DEVICE_MODE, 8'h40);
        rdc("status", `OFF_DCH_STATUS, dbl(0, 0, 0, 0));
        for (int k = 1; k <= 2; k++) begin
            ev(8'h10);
            rdc("status", `OFF_DCH_STATUS, dbl(k, 0, 0, 0));
        end
        for (int k = 1; k >= 0; k--) begin
            rd(`OFF_RX_BYTE0 + 16'h0005, got);
            rdc("status", `OFF_DCH_STATUS, dbl(k, 0, 0, 0));
        end
        ev(8'h40);
        rdc("status", `OFF_DCH_STATUS, dbl(0, 0, 1, 0));
        rdc("status", `OFF_DCH_STATUS, dbl(0, 0, 0, 0));
        ev(8'h04);
        rdc("status", `OFF_DCH_STATUS, dbl(0, 0, 0, 1));
        rd(`OFF_RX_BYTE0, got);
        rdc("status", `OFF_DCH_STATUS, dbl(0, 0, 0, 0));
        for (int k = 1; k <= 2; k++) begin
            wr(`OFF_TX_BYTE0 + 16'h0005, byte_type'($urandom));
            rdc("status", `OFF_DCH_STATUS, dbl(0, k, 0, 0));
        end
        ev(8'h20);
        rdc("status", `OFF_DCH_STATUS, dbl(0, 1, 0, 0));
        // crc error on the word that lands in the visible half
        ev(8'h01);
        ev(8'h10);
        rdc("status", `OFF_DCH_STATUS, dbl(1, 1, 0, 0) | 8'h02);
        irqc(1'b1);
        ev(8'h10);
        rd(`OFF_RX_BYTE0 + 16'h0005, got);
        rdc("status", `OFF_DCH_STATUS, dbl(1, 1, 0, 0));
        // second reset in mid-run must bring back single mode defaults
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdc("status", `OFF_DCH_STATUS, sgl(1, 0, 0));
        rdc("mode", `OFF_DEVICE_MODE, 8'h00);
        give_verdict();
    end

    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        give_verdict();
    end
endmodule : testbench
